// File: shared/rci_pkg.sv
// Constants for the real-time control input decoder
package rci_pkg;
  // Serial frame layout, first bit received lands in the MSB
  localparam int FRAME_BITS      = 48;
  localparam int LINE_INC_MSB    = 47;
  localparam int LINE_INC_LSB    = 32;
  localparam int FSC_INC_W       = 24;
  localparam int FSC_INC_MSB     = 31;
  localparam int FSC_INC_LSB     = 8;
  localparam int FR_PAL_BIT      = 7;
  localparam int FR_RESET_BIT    = 6;
  localparam int FR_FIELD_BIT    = 5;
  localparam int FR_ODD_EVEN_BIT = 4;
  localparam int FR_COLOUR_BIT   = 3;
  localparam int CNT_W           = 6;

  // Wishbone register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] ADR_INT_INC = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 8'h08;
  localparam logic [ADR_W-1:0] ADR_EFF_INC = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_FRAMES  = 8'h10;

  // Control register fields
  localparam int CTRL_W          = 8;
  localparam int CT_RT_EN        = 0;
  localparam int CT_PH_EN        = 1;
  localparam int CT_PH_MODE_LSB  = 2;
  localparam int CT_FIS_EN       = 4;
  localparam int CT_OE_EN        = 5;
  localparam int CT_COL_EN       = 6;
  localparam int CT_FIS_REG      = 7;
  localparam logic [1:0] PH_MODE_LINE = 2'h0;

  // Reset values
  localparam logic [CTRL_W-1:0]    CTRL_RST    = 8'h00;
  localparam logic [FSC_INC_W-1:0] INT_INC_RST = 24'h000000;
  localparam int FRAME_CNT_W = 16;
endpackage

// File: shared/rci_frame_if.sv
// Carrier for a completed serial frame between shifter and decoder
interface rci_frame_if;
  import rci_pkg::*;
  logic [FRAME_BITS-1:0] frame;  // Last complete frame
  logic                  valid;  // One-cycle pulse per complete frame
  modport src (output frame, output valid);
  modport dst (input frame, input valid);
endinterface

// File: verilog/rci_shift.sv
// Serial frame shifter: assembles one complete control frame
module rci_shift (
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  input  wire logic    bit_strobe,
  input  wire logic    bit_data,
  input  wire logic    frame_start,
  rci_frame_if.src     fr
);
  import rci_pkg::*;

  typedef struct packed {
    logic [FRAME_BITS-1:0] sh;     // Bits gathered so far
    logic [CNT_W-1:0]      cnt;    // Bits received in this frame
    logic                  busy;   // A frame is in progress
    logic [FRAME_BITS-1:0] frame;  // Published frame
    logic                  valid;  // Publish pulse
  } rci_shift_s;

  rci_shift_s st;       // Registered state
  rci_shift_s next_st;  // Next state

  // Shift per bit strobe; publish only at the last bit
  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    if (bit_strobe) begin
      if (frame_start) begin
        // Start marker restarts, dropping any partial frame
        next_st.sh   = {{(FRAME_BITS-1){1'b0}}, bit_data};
        next_st.cnt  = CNT_W'(1);
        next_st.busy = 1'b1;
      end else if (st.busy) begin
        next_st.sh  = {st.sh[FRAME_BITS-2:0], bit_data};
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
    // Complete frame copied out in one step, never partly
    if (next_st.busy && next_st.cnt == CNT_W'(FRAME_BITS)) begin
      next_st.frame = next_st.sh;
      next_st.valid = 1'b1;
      next_st.busy  = 1'b0;
      next_st.cnt   = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fr.frame = st.frame;
  assign fr.valid = st.valid;
endmodule

// File: verilog/rci_top.sv
// Real-time control input decoder with Wishbone register access
module rci_top (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  // Serial control stream pins
  input  wire logic                           line_locked_clock,
  input  wire logic                           realtime_control_input,
  input  wire logic                           realtime_frame_start,
  // Internally generated odd/even flag, same clock
  input  wire logic                           internal_odd_even,
  // Wishbone classic slave
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [rci_pkg::ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  // Decoded controls to the encoder
  output logic      [rci_pkg::FSC_INC_W-1:0]  subcarrier_increment,
  output logic                                subcarrier_phase_reset,
  output logic                                field_rate_select,
  output logic                                odd_even_field,
  output logic                                pal_line
);
  import rci_pkg::*;

  // All state of the decoder apart from the frame shifter
  typedef struct packed {
    logic                   llc_s1;     // Clock pin, first sync stage
    logic                   llc_s2;     // Clock pin, second sync stage
    logic                   llc_d;      // Delayed copy for edge detect
    logic                   dat_s1;     // Data pin, first stage
    logic                   dat_s2;     // Data pin, second stage
    logic                   sta_s1;     // Start pin, first stage
    logic                   sta_s2;     // Start pin, second stage
    logic                   strobe;     // Sample strobe toward shifter
    logic                   bit_d;      // Data sampled with strobe
    logic                   sta_d;      // Start sampled with strobe
    logic [CTRL_W-1:0]      ctrl;       // Enable and mode bits
    logic [FSC_INC_W-1:0]   int_inc;    // Own subcarrier increment
    logic [FSC_INC_W-1:0]   rx_inc;     // Received subcarrier increment
    logic                   rx_pal;     // Received PAL flag
    logic                   rx_field;   // Received field-rate flag
    logic                   rx_oe;      // Received odd/even flag
    logic                   rx_col;     // Received colour detect flag
    logic                   rx_seen;    // At least one frame decoded
    logic [FRAME_CNT_W-1:0] frames;     // Complete frames received
    logic [FSC_INC_W-1:0]   inc_out;    // Subcarrier increment output
    logic                   ph_rst;     // Phase reset pulse output
    logic                   fis_out;    // Field-rate output
    logic                   oe_out;     // Odd/even output
    logic                   pal_out;    // PAL line output
    logic                   from_rx;    // Increment taken from stream
    logic [31:0]            dat;        // Wishbone read data
    logic                   ack;        // Wishbone acknowledge
  } rci_top_s;

  rci_top_s st;       // Registered state
  rci_top_s next_st;  // Next state

  rci_frame_if fr ();  // Frame from shifter

  // Byte-lane merge for partial Wishbone writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Shifter sees only synchronised, strobed samples
  rci_shift u_shift (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .bit_strobe  (st.strobe),
    .bit_data    (st.bit_d),
    .frame_start (st.sta_d),
    .fr          (fr.src)
  );

  logic        rt_en;       // Real-time input enable
  logic        ph_en;       // Phase reset decode enable
  logic [1:0]  ph_mode;     // Phase reset mode
  logic        fis_en;      // Field-rate decode enable
  logic        oe_en;       // Odd/even decode enable
  logic        col_en;      // Colour detect decode enable
  logic        wr_hit;      // Write accepted this cycle
  logic [31:0] wr_ctrl;     // Merged control write value
  logic [31:0] wr_inc;      // Merged increment write value
  logic        use_rx_inc;  // Select received increment
  logic        rx_ok;       // Stream values usable

  // Zero-extend a subcarrier increment onto the 32-bit data bus
  function automatic logic [31:0] widen_inc(
    input logic [FSC_INC_W-1:0] v
  );
    return {{(32-FSC_INC_W){1'b0}}, v};
  endfunction

  assign rt_en   = st.ctrl[CT_RT_EN];
  assign ph_en   = st.ctrl[CT_PH_EN];
  assign ph_mode = st.ctrl[CT_PH_MODE_LSB +: 2];
  assign fis_en  = st.ctrl[CT_FIS_EN];
  assign oe_en   = st.ctrl[CT_OE_EN];
  assign col_en  = st.ctrl[CT_COL_EN];
  // Before the first frame, stream values are not trusted
  assign rx_ok   = rt_en && st.rx_seen;

  // Subcarrier source: received when stream values usable, unless colour decode says no colour
  assign use_rx_inc = rx_ok && (!col_en || st.rx_col);

  // A write lands at the edge where the master sees ack high,
  // so a master that gives up early never leaves a half write
  assign wr_hit  = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
  assign wr_ctrl = lane_merge({{(32-CTRL_W){1'b0}}, st.ctrl},
                              wb_dat_i, wb_sel_i);
  assign wr_inc  = lane_merge(widen_inc(st.int_inc), wb_dat_i, wb_sel_i);

  // Next-state logic for sync, decode, outputs and bus
  always_comb begin
    next_st = st;
    // Two-stage synchronisers; first stages feed only second stages
    next_st.llc_s1 = line_locked_clock;
    next_st.llc_s2 = st.llc_s1;
    next_st.dat_s1 = realtime_control_input;
    next_st.dat_s2 = st.dat_s1;
    next_st.sta_s1 = realtime_frame_start;
    next_st.sta_s2 = st.sta_s1;
    next_st.llc_d  = st.llc_s2;
    // Sample data on the rising edge of the line-locked clock
    next_st.strobe = st.llc_s2 && !st.llc_d;
    next_st.bit_d  = st.dat_s2;
    next_st.sta_d  = st.sta_s2;
    next_st.ph_rst = 1'b0;

    // Frame decode; line PLL increment bits are never read
    if (fr.valid) begin
      next_st.rx_inc   = fr.frame[FSC_INC_MSB:FSC_INC_LSB];
      next_st.rx_pal   = fr.frame[FR_PAL_BIT];
      next_st.rx_field = fr.frame[FR_FIELD_BIT];
      next_st.rx_oe    = fr.frame[FR_ODD_EVEN_BIT];
      next_st.rx_col   = fr.frame[FR_COLOUR_BIT];
      next_st.rx_seen  = 1'b1;
      next_st.frames   = st.frames + FRAME_CNT_W'(1);
      // Phase reset once per line that carries the reset flag
      if (rt_en && ph_en && ph_mode == PH_MODE_LINE &&
          fr.frame[FR_RESET_BIT]) begin
        next_st.ph_rst = 1'b1;
      end
    end

    // Effective outputs, internal values when stream disabled
    next_st.from_rx = use_rx_inc;
    if (use_rx_inc) begin
      next_st.inc_out = st.rx_inc;
    end else begin
      next_st.inc_out = st.int_inc;
    end
    if (rx_ok && fis_en) begin
      next_st.fis_out = st.rx_field;
    end else begin
      next_st.fis_out = st.ctrl[CT_FIS_REG];
    end
    if (rx_ok && oe_en) begin
      next_st.oe_out = st.rx_oe;
    end else begin
      next_st.oe_out = internal_odd_even;
    end
    next_st.pal_out = rx_ok && st.rx_pal;

    // Wishbone: answer one cycle after the request, drop after one
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.dat = 32'h00000000;
    if (wr_hit) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          next_st.ctrl = wr_ctrl[CTRL_W-1:0];
        end
        ADR_INT_INC: begin
          next_st.int_inc = wr_inc[FSC_INC_W-1:0];
        end
        default: begin
          // Read-only or unmapped: write ignored, still acked
        end
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          next_st.dat = {{(32-CTRL_W){1'b0}}, st.ctrl};
        end
        ADR_INT_INC: begin
          next_st.dat = widen_inc(st.int_inc);
        end
        ADR_STATUS: begin
          next_st.dat = {24'h000000, st.from_rx, st.rx_seen,
                         st.rx_col, st.rx_oe, st.rx_field, st.rx_pal,
                         st.oe_out, st.fis_out};
        end
        ADR_EFF_INC: begin
          next_st.dat = widen_inc(st.inc_out);
        end
        ADR_FRAMES: begin
          next_st.dat = {{(32-FRAME_CNT_W){1'b0}}, st.frames};
        end
        default: begin
          // Unmapped reads return zero
          next_st.dat = 32'h00000000;
        end
      endcase
    end
  end

  // State register; reset gives internal sources everywhere
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st         <= '0;
      st.ctrl    <= CTRL_RST;
      st.int_inc <= INT_INC_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops
  assign wb_dat_o               = st.dat;
  assign wb_ack_o               = st.ack;
  assign subcarrier_increment   = st.inc_out;
  assign subcarrier_phase_reset = st.ph_rst;
  assign field_rate_select      = st.fis_out;
  assign odd_even_field         = st.oe_out;
  assign pal_line               = st.pal_out;
endmodule

// File: verif/rci_top_asserts.sv
// Port-level checker for the real-time control input decoder
module rci_top_asserts (
  input wire logic                      ref_clk,
  input wire logic                      rst_b,
  input wire logic                      internal_odd_even,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [rci_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic                      wb_ack_o,
  input wire logic [23:0]               subcarrier_increment,
  input wire logic                      subcarrier_phase_reset,
  input wire logic                      field_rate_select,
  input wire logic                      odd_even_field,
  input wire logic                      pal_line
);
  timeunit 1ns;
  timeprecision 1ns;
  import rci_pkg::*;
  logic [7:0]  sh_ctrl;  // Shadow of the control byte
  logic [23:0] sh_inc;   // Shadow of the own increment
  logic        wr;       // Write taken at this edge
  logic        rt_on;    // Stream in use
  logic        ph_ok;    // Phase reset decoding allowed
  logic        fis_use;  // Stream field rate in use
  logic        oe_use;   // Stream odd/even in use
  logic        fis_reg;  // Register copy of field rate
  assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rt_on   = sh_ctrl[CT_RT_EN];
  assign ph_ok   = rt_on && sh_ctrl[CT_PH_EN] && sh_ctrl[3:2] == PH_MODE_LINE;
  assign fis_use = rt_on && sh_ctrl[CT_FIS_EN];
  assign oe_use  = rt_on && sh_ctrl[CT_OE_EN];
  assign fis_reg = sh_ctrl[CT_FIS_REG];
  // Mirror writes at the edge that takes them, so no decode is needed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_ctrl <= CTRL_RST;
      sh_inc  <= INT_INC_RST;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) sh_ctrl <= wb_dat_i[7:0];
      for (int b = 0; b < 3; b++) begin
        if (wb_adr_i == ADR_INT_INC && wb_sel_i[b])
          sh_inc[8*b+:8] <= wb_dat_i[8*b+:8];
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_off_own_inc: assert property (
    !rt_on |=> subcarrier_increment == $past(sh_inc))
    else $error("increment not internal while stream off");
  a_off_no_pal: assert property (!rt_on |=> !pal_line)
    else $error("pal flag while stream off");
  a_off_no_phase: assert property (!rt_on |=> !subcarrier_phase_reset)
    else $error("phase reset while stream off");
  a_phase_gated: assert property (subcarrier_phase_reset |-> $past(ph_ok))
    else $error("phase reset without mode 00 enables");
  a_phase_pulse: assert property (
    $rose(subcarrier_phase_reset) |=> !subcarrier_phase_reset)
    else $error("phase reset longer than one cycle");
  a_fis_copy: assert property (
    !fis_use |=> field_rate_select == $past(fis_reg))
    else $error("field rate not register copy");
  a_oe_internal: assert property (
    !oe_use |=> odd_even_field == $past(internal_odd_even))
    else $error("odd/even not internal flag");
endmodule
bind rci_top rci_top_asserts i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .internal_odd_even(internal_odd_even),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .subcarrier_increment(subcarrier_increment),
  .subcarrier_phase_reset(subcarrier_phase_reset),
  .field_rate_select(field_rate_select), .odd_even_field(odd_even_field),
  .pal_line(pal_line));

// File: verif/rci_sender.sv
// Model of the external decoder that sends the control stream
module rci_sender (
  input  wire logic ref_clk,
  output logic      llc,
  output logic      sdat,
  output logic      start
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bit clock stands low outside frames
  initial begin
    llc   = 1'b0;
    sdat  = 1'b0;
    start = 1'b0;
  end
  // Send nb bits MSB first, each level h ref_clk periods long;
  // the caller sets the PAL flag in bit 7 of f for inverted lines
  task automatic send(input logic [47:0] f, input int nb, input int h);
    for (int i = 0; i < nb; i++) begin
      sdat  <= f[47-i];
      start <= (i == 0);
      repeat (h) @(posedge ref_clk);
      llc <= 1'b1;
      repeat (h) @(posedge ref_clk);
      llc <= 1'b0;
    end
    // Released line shows no stale bit
    sdat  <= ~sdat;
    start <= 1'b0;
  endtask
endmodule

// File: verif/rci_top_tb.sv
// Self-checking bench for the real-time control input decoder
module rci_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rci_pkg::*;
  logic        ref_clk, rst_b, ioe, cyc, stb, we, ack;
  logic        ph, fis, oe, pal, llc, sd, st, b;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  logic [23:0] inc, ri, r2;
  logic [31:0] rq[$];   // Expected read data, oldest first
  int          errors, cmp_count, pulses, cyc_n, p0;
  rci_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .line_locked_clock(llc), .realtime_control_input(sd),
    .realtime_frame_start(st), .internal_odd_even(ioe), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .subcarrier_increment(inc), .subcarrier_phase_reset(ph),
    .field_rate_select(fis), .odd_even_field(oe), .pal_line(pal));
  rci_sender i_snd (.ref_clk(ref_clk), .llc(llc), .sdat(sd), .start(st));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string w, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One classic cycle; on reads d is the expected data
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    if (!w) rq.push_back(d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) chk("wb_ack_o", 32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [47:0] mk(input logic [23:0] i,
                                     input logic [4:0] fl);
    return {16'($urandom), i, fl, 3'h0}; // Line increment is noise
  endfunction
  // Full or cut frame, then time for the decode to land
  task automatic frame(input logic [47:0] f, input int nb, input int h);
    i_snd.send(f, nb, h);
    repeat (12) @(posedge ref_clk);
  endtask
  // Monitor: read data against oldest note, pulses, timeout, odd/even
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
      chk("wb_dat_o", dr, rq.pop_front());
    if (ph === 1'b1) pulses++;
    ioe <= 1'($urandom);
    cyc_n++;
    if (cyc_n == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {rst_b, cyc, stb, we, adr, sel, dw} = '0;
    void'($urandom(83706));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    // Reset values, unmapped read, byte enables, read-only place
    wb(0, ADR_CTRL, 32'(CTRL_RST), 4'hF);
    wb(0, ADR_INT_INC, 32'(INT_INC_RST), 4'hF);
    wb(0, 8'h20, 32'h0, 4'hF);
    ri = 24'($urandom);
    wb(1, ADR_INT_INC, 32'(ri), 4'hF);
    wb(1, ADR_INT_INC, 32'hFFFFFFAB, 4'h1);
    ri[7:0] = 8'hAB;
    wb(0, ADR_INT_INC, 32'(ri), 4'h0);
    wb(1, ADR_EFF_INC, 32'h55, 4'hF);
    wb(0, ADR_EFF_INC, 32'(ri), 4'hF);
    // Stream off: a full frame with every flag but field rate must change nothing
    wb(1, ADR_CTRL, 32'hF2, 4'hF);
    frame(mk(~ri, 5'h1B), 48, 2);
    chk("subcarrier_increment", 32'(inc), 32'(ri));
    chk("pal_line", 32'(pal), 32'h0);
    chk("field_rate_select", 32'(fis), 32'h1);
    chk("phase_pulses", 32'(pulses), 32'h0);
    // Each phase mode, all decodes on but colour, prompt and slow sender
    for (int m = 0; m < 4; m++) begin
      p0 = pulses;
      wb(1, ADR_CTRL, 32'h33 | 32'(m << 2), 4'hF);
      r2 = 24'($urandom);
      b = 1'($urandom);
      frame(mk(r2, {3'b111, b, 1'b0}), 48, 2 + m % 2);
      chk("subcarrier_increment", 32'(inc), 32'(r2));
      chk("phase_pulses", 32'(pulses - p0), 32'(m == 0));
      chk("field_rate_select", 32'(fis), 32'h1);
      chk("odd_even_field", 32'(oe), 32'(b));
      chk("pal_line", 32'(pal), 32'h1);
    end
    // Colour decode on: own source until colour is seen
    for (int c = 0; c < 2; c++) begin
      wb(1, ADR_CTRL, 32'hC1, 4'hF);
      r2 = 24'($urandom);
      frame(mk(r2, 5'(c)), 48, 2);
      chk("subcarrier_increment", 32'(inc), 32'(c ? r2 : ri));
      chk("field_rate_select", 32'(fis), 32'h1);
    end
    // A cut frame is dropped; the next start begins afresh
    frame(mk(~r2, 5'h1), 20, 2);
    chk("subcarrier_increment", 32'(inc), 32'(r2));
    frame(mk(r2 ^ 24'h1, 5'h1), 48, 3);
    chk("subcarrier_increment", 32'(inc), 32'(r2 ^ 24'h1));
    wb(0, ADR_EFF_INC, 32'(r2 ^ 24'h1), 4'hF);
    // Odd/even from stream so every status bit is known
    wb(1, ADR_CTRL, 32'hE1, 4'hF);
    wb(0, ADR_STATUS, 32'hE1, 4'hF);
    wb(0, ADR_FRAMES, 32'h8, 4'hF);
    conclude();
  end
endmodule
